// ---- i2c_host_model.sv ----
`timescale 1ns/1ps
module i2c_host_model #(
  parameter logic [6:0] DEV_ADDR = 7'h31 // Arbitrary value, same as the device default
) (
  input wire logic sys_clk_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_pull_o,
  output logic duty_o
);
  int duty_high;
  int pwm_cnt;
  initial begin
    scl_o = 1'b1;
    sda_pull_o = 1'b0;
    duty_o = 1'b0;
    duty_high = 0;
    pwm_cnt = 0;
  end
  // Source period equals the measuring window, so the measured duty is exact
  always @(posedge sys_clk_i) begin
    pwm_cnt <= (pwm_cnt == 1022) ? 0 : pwm_cnt + 1;
    duty_o <= (pwm_cnt < duty_high);
  end
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask
  // Both SCL phases last 8 clocks, twice the minimum, so the synchroniser never misses an edge
  task automatic put_bit(input logic b, output logic seen);
    sda_pull_o <= ~b;
    tick(4);
    scl_o <= 1'b1;
    tick(8);
    seen = sda_i;
    scl_o <= 1'b0;
    tick(4);
  endtask
  task automatic put_byte(input logic [7:0] d, output logic [7:0] q, output logic nack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      put_bit(d[i], s);
      q[i] = s;
    end
    put_bit(1'b1, nack);
  endtask
  task automatic start_cond();
    tick(1);
    sda_pull_o <= 1'b1;
    tick(8);
    scl_o <= 1'b0;
    tick(4);
  endtask
  task automatic stop_cond();
    sda_pull_o <= 1'b1;
    tick(4);
    scl_o <= 1'b1;
    tick(8);
    sda_pull_o <= 1'b0;
    tick(8);
  endtask
  task automatic write_reg(input logic [6:0] dev, input logic [7:0] a, input logic [7:0] d, output logic nack);
    logic [7:0] q;
    logic n0, n1, n2;
    start_cond();
    put_byte({dev, 1'b0}, q, n0);
    put_byte(a, q, n1);
    put_byte(d, q, n2);
    stop_cond();
    nack = n0 | n1 | n2;
  endtask
  // Pointer is set by a write, then a fresh transfer reads one byte and ends it with a NACK
  task automatic read_reg(input logic [7:0] a, output logic [7:0] q);
    logic [7:0] unused;
    logic n;
    start_cond();
    put_byte({DEV_ADDR, 1'b0}, unused, n);
    put_byte(a, unused, n);
    stop_cond();
    start_cond();
    put_byte({DEV_ADDR, 1'b1}, unused, n);
    put_byte(8'hff, q, n);
    stop_cond();
  endtask
endmodule

// ---- led_dim_pkg.sv ----
package led_dim_pkg;
  localparam int CLK_PERIOD_NS = 100;
  localparam int REG_COUNT = 12;
  localparam logic [7:0] ADDR_MODE = 8'h00;
  localparam logic [7:0] ADDR_CFG = 8'h01;
  localparam logic [7:0] ADDR_CURRENT = 8'h02;
  localparam logic [7:0] ADDR_COMP = 8'h03;
  localparam logic [7:0] ADDR_P1_LO = 8'h04;
  localparam logic [7:0] ADDR_P1_HI = 8'h05;
  localparam logic [7:0] ADDR_P2_LO = 8'h06;
  localparam logic [7:0] ADDR_P2_HI = 8'h07;
  localparam logic [7:0] ADDR_ADV = 8'h08;
  localparam logic [7:0] ADDR_FADE = 8'h09;
  localparam logic [7:0] ADDR_SS = 8'h0a;
  localparam logic [7:0] ADDR_STOP = 8'h0b;
  localparam logic [7:0] RST_MODE = 8'h40;
  localparam logic [7:0] RST_CFG = 8'h76;
  localparam logic [7:0] RST_CURRENT = 8'h92;
  localparam logic [7:0] RST_FADE = 8'h1c;
  localparam logic [7:0] RST_ZERO = 8'h00;
  // Field positions
  localparam int MODE_MIX_BIT = 0;
  localparam int MODE_SRC_BIT = 1;
  localparam int MODE_MIXDUTY_LSB = 2;
  localparam int MODE_26K_BIT = 7;
  localparam int CFG_TEN_BIT = 7;
  localparam int COMP_K_MSB = 4;
  localparam int ADV_SEL_MSB = 1;
  localparam int ADV_HEAD_LSB = 2;
  localparam int ADV_SLOPE_LSB = 4;
  localparam int FADE_DITHER_BIT = 4;
  localparam int FADE_TIME_LSB = 5;
  localparam logic [9:0] FULL_CODE = 10'h3ff;
  localparam logic [4:0] COMP_DIV = 5'h1f;
  localparam logic [9:0] OCTAVE0_TOP = 10'h010;
  // Headroom targets in mV
  localparam logic [9:0] HEAD_MV0 = 10'd500;
  localparam logic [9:0] HEAD_MV1 = 10'd570;
  localparam logic [9:0] HEAD_MV2 = 10'd600;
  localparam logic [9:0] HEAD_MV3 = 10'd700;
  // Fade step hold times in ns
  localparam int FADE_T0_NS = 500;
  localparam int FADE_T1_NS = 1000;
  localparam int FADE_T2_NS = 2000;
  localparam int FADE_T3_NS = 4000;
  localparam logic [15:0] FADE_C0 = 16'(FADE_T0_NS / CLK_PERIOD_NS);
  localparam logic [15:0] FADE_C1 = 16'(FADE_T1_NS / CLK_PERIOD_NS);
  localparam logic [15:0] FADE_C2 = 16'(FADE_T2_NS / CLK_PERIOD_NS);
  localparam logic [15:0] FADE_C3 = 16'(FADE_T3_NS / CLK_PERIOD_NS);
  // Shortest full ramp in us, split in seven octaves of 512 steps
  localparam int SLOPE_MIN_US = 7800;
  localparam int OCTAVES = 7;
  localparam int OCTAVE_STEPS = 512;
  localparam logic [15:0] SLOPE_STEP_CYC = 16'(SLOPE_MIN_US * 1000 / OCTAVES / OCTAVE_STEPS / CLK_PERIOD_NS);
endpackage

// ---- led_dimming_control.sv ----
`timescale 1ns/1ps
module led_dimming_control #(
  parameter logic [6:0] SLAVE_ADDR = 7'h31 // Arbitrary value
) (
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic external_duty_input_i,
  input wire logic [47:0] sink_feedback_voltage_i,
  output logic dimming_output_duty_o,
  output logic [7:0] full_scale_led_current_o,
  output logic [7:0] error_amplifier_o,
  output logic [9:0] headroom_target_mv_o,
  output logic register_dc_dimming_mode_o
);
  typedef enum {ST_IDLE, ST_ADDR, ST_PTR, ST_WR, ST_RD} i2c_st_e;

  logic [2:0] sync_w;
  logic scl_s, sda_s, pwm_s;
  logic scl_d_ff, sda_d_ff;
  i2c_st_e st_ff;
  logic [3:0] cnt_ff;
  logic [7:0] shift_ff, tx_ff, ptr_ff;
  logic ack_ff;
  logic wr_stb_ff;
  logic [7:0] wr_addr_ff, wr_data_ff;
  logic [7:0] regs_ff [led_dim_pkg::REG_COUNT];
  logic [9:0] pair1_ff, pair2_ff;
  logic [7:0] rd_byte;

  sync2 #(.WIDTH(3)) u_sync (
    .sys_clk_i(sys_clk_i),
    .rst_b_i(rst_b_i),
    .async_i({scl_i, sda_i, external_duty_input_i}),
    .sync_o(sync_w)
  );
  assign scl_s = sync_w[2];
  assign sda_s = sync_w[1];
  assign pwm_s = sync_w[0];
  assign sda_o = 1'b0;

  wire scl_rise = scl_s & ~scl_d_ff;
  wire scl_fall = ~scl_s & scl_d_ff;
  wire start_c = scl_s & scl_d_ff & sda_d_ff & ~sda_s;
  wire stop_c = scl_s & scl_d_ff & ~sda_d_ff & sda_s;

  always_comb begin
    rd_byte = 8'h00;
    if (ptr_ff < 8'(led_dim_pkg::REG_COUNT)) begin
      rd_byte = regs_ff[ptr_ff[3:0]];
    end
  end

  // Serial register port; open drain, so only low is ever driven
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      scl_d_ff <= 1'b1;
      sda_d_ff <= 1'b1;
      st_ff <= ST_IDLE;
      cnt_ff <= 4'h0;
      shift_ff <= 8'h00;
      tx_ff <= 8'h00;
      ptr_ff <= 8'h00;
      ack_ff <= 1'b0;
      sda_oe_o <= 1'b0;
      wr_stb_ff <= 1'b0;
      wr_addr_ff <= 8'h00;
      wr_data_ff <= 8'h00;
    end else begin
      scl_d_ff <= scl_s;
      sda_d_ff <= sda_s;
      wr_stb_ff <= 1'b0;
      if (start_c) begin
        st_ff <= ST_ADDR;
        cnt_ff <= 4'h0;
        ack_ff <= 1'b0;
        sda_oe_o <= 1'b0;
      end else if (stop_c) begin
        st_ff <= ST_IDLE;
        ack_ff <= 1'b0;
        sda_oe_o <= 1'b0;
      end else if (scl_rise && st_ff != ST_IDLE) begin
        if (ack_ff) begin
          if (st_ff == ST_RD && sda_s) begin
            st_ff <= ST_IDLE;
            ack_ff <= 1'b0;
          end
        end else begin
          shift_ff <= {shift_ff[6:0], sda_s};
          cnt_ff <= cnt_ff + 4'h1;
        end
      end else if (scl_fall && st_ff != ST_IDLE) begin
        if (ack_ff) begin
          ack_ff <= 1'b0;
          cnt_ff <= 4'h0;
          sda_oe_o <= 1'b0;
          if (st_ff == ST_RD) begin
            sda_oe_o <= ~rd_byte[7];
            tx_ff <= {rd_byte[6:0], 1'b0};
            ptr_ff <= ptr_ff + 8'h01;
          end
        end else if (cnt_ff == 4'h8) begin
          ack_ff <= 1'b1;
          sda_oe_o <= 1'b1;
          case (st_ff)
            ST_ADDR: begin
              if (shift_ff[7:1] != SLAVE_ADDR) begin
                st_ff <= ST_IDLE;
                ack_ff <= 1'b0;
                sda_oe_o <= 1'b0;
              end else if (shift_ff[0]) begin
                st_ff <= ST_RD;
              end else begin
                st_ff <= ST_PTR;
              end
            end
            ST_PTR: begin
              ptr_ff <= shift_ff;
              st_ff <= ST_WR;
            end
            ST_WR: begin
              wr_stb_ff <= 1'b1;
              wr_addr_ff <= ptr_ff;
              wr_data_ff <= shift_ff;
              ptr_ff <= ptr_ff + 8'h01;
            end
            default: begin
              sda_oe_o <= 1'b0;
            end
          endcase
        end else if (st_ff == ST_RD) begin
          sda_oe_o <= ~tx_ff[7];
          tx_ff <= {tx_ff[6:0], 1'b0};
        end
      end
    end
  end

  // Register file; unmapped writes are dropped
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      for (int i = 0; i < led_dim_pkg::REG_COUNT; i++) begin
        regs_ff[i] <= led_dim_pkg::RST_ZERO;
      end
      regs_ff[led_dim_pkg::ADDR_MODE[3:0]] <= led_dim_pkg::RST_MODE;
      regs_ff[led_dim_pkg::ADDR_CFG[3:0]] <= led_dim_pkg::RST_CFG;
      regs_ff[led_dim_pkg::ADDR_CURRENT[3:0]] <= led_dim_pkg::RST_CURRENT;
      regs_ff[led_dim_pkg::ADDR_FADE[3:0]] <= led_dim_pkg::RST_FADE;
    end else if (wr_stb_ff && wr_addr_ff < 8'(led_dim_pkg::REG_COUNT)) begin
      regs_ff[wr_addr_ff[3:0]] <= wr_data_ff;
    end
  end

  wire ten_bit = regs_ff[led_dim_pkg::ADDR_CFG[3:0]][led_dim_pkg::CFG_TEN_BIT];

  // Pairs apply as one unit; the upper half commits in 10-bit mode
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pair1_ff <= 10'h000;
      pair2_ff <= 10'h000;
    end else if (wr_stb_ff) begin
      if (ten_bit) begin
        if (wr_addr_ff == led_dim_pkg::ADDR_P1_HI) begin
          pair1_ff <= {wr_data_ff[1:0], regs_ff[led_dim_pkg::ADDR_P1_LO[3:0]]};
        end else if (wr_addr_ff == led_dim_pkg::ADDR_P2_HI) begin
          pair2_ff <= {wr_data_ff[1:0], regs_ff[led_dim_pkg::ADDR_P2_LO[3:0]]};
        end
      end else if (wr_addr_ff == led_dim_pkg::ADDR_P1_LO) begin
        pair1_ff <= {wr_data_ff, wr_data_ff[7:6]};
      end else if (wr_addr_ff == led_dim_pkg::ADDR_P2_LO) begin
        pair2_ff <= {wr_data_ff, wr_data_ff[7:6]};
      end
    end
  end

  // Input duty over a fixed 1023-sample window: no divider needed
  logic [9:0] win_ff, high_ff, pwm_duty_ff;
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      win_ff <= 10'h000;
      high_ff <= 10'h000;
      pwm_duty_ff <= 10'h000;
    end else if (win_ff == led_dim_pkg::FULL_CODE - 10'h001) begin
      win_ff <= 10'h000;
      high_ff <= 10'h000;
      pwm_duty_ff <= high_ff + {9'h000, pwm_s};
    end else begin
      win_ff <= win_ff + 10'h001;
      high_ff <= high_ff + {9'h000, pwm_s};
    end
  end

  // Source and mode selection
  wire [7:0] mode = regs_ff[led_dim_pkg::ADDR_MODE[3:0]];
  wire [7:0] adv = regs_ff[led_dim_pkg::ADDR_ADV[3:0]];
  wire [7:0] fade = regs_ff[led_dim_pkg::ADDR_FADE[3:0]];
  wire src_reg = mode[led_dim_pkg::MODE_SRC_BIT];
  wire dc_mode = mode[led_dim_pkg::MODE_26K_BIT] & src_reg & mode[led_dim_pkg::MODE_MIX_BIT] &
                 (mode[led_dim_pkg::MODE_MIXDUTY_LSB+1:led_dim_pkg::MODE_MIXDUTY_LSB] == 2'b00);
  logic [9:0] src_code, level_code, duty_code;
  logic [19:0] prod;
  always_comb begin
    src_code = src_reg ? pair1_ff : pwm_duty_ff;
    prod = 20'h00000;
    level_code = src_code;
    duty_code = src_code;
    if (adv[led_dim_pkg::ADV_SEL_MSB]) begin
      prod = src_code * pair2_ff;
      level_code = prod[19:10];
    end else if (adv[0] && !src_reg) begin
      prod = pwm_duty_ff * pair1_ff;
      level_code = prod[19:10];
    end
    if (dc_mode) begin
      duty_code = led_dim_pkg::FULL_CODE;
    end
  end

  // Ramp timing: smart dither slope, DC fade, soft-start stretch
  logic [9:0] ramp_ff;
  logic [15:0] step_cnt_ff, step_cyc;
  logic soft_ff;
  wire [2:0] slope = adv[led_dim_pkg::ADV_SLOPE_LSB+2:led_dim_pkg::ADV_SLOPE_LSB];
  wire dither_en = fade[led_dim_pkg::FADE_DITHER_BIT];
  wire [1:0] ss_mult = regs_ff[led_dim_pkg::ADDR_SS[3:0]][1:0];
  always_comb begin
    case (fade[led_dim_pkg::FADE_TIME_LSB+1:led_dim_pkg::FADE_TIME_LSB])
      2'b00: step_cyc = led_dim_pkg::FADE_C0;
      2'b01: step_cyc = led_dim_pkg::FADE_C1;
      2'b10: step_cyc = led_dim_pkg::FADE_C2;
      default: step_cyc = led_dim_pkg::FADE_C3;
    endcase
    if (dither_en && !dc_mode) begin
      step_cyc = led_dim_pkg::SLOPE_STEP_CYC << ((slope == 3'h0) ? 3'h0 : slope - 3'h1);
      if (ramp_ff < led_dim_pkg::OCTAVE0_TOP) begin
        step_cyc = step_cyc >> 1;
      end
    end
    if (soft_ff) begin
      step_cyc = step_cyc << ss_mult;
    end
  end

  wire ramp_on = dither_en | dc_mode | soft_ff;
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ramp_ff <= 10'h000;
      step_cnt_ff <= 16'h0000;
      soft_ff <= 1'b1;
    end else if (!ramp_on) begin
      ramp_ff <= level_code;
      step_cnt_ff <= 16'h0000;
    end else if (ramp_ff == level_code) begin
      step_cnt_ff <= 16'h0000;
      soft_ff <= soft_ff & (level_code == 10'h000);
    end else if (step_cnt_ff + 16'h0001 >= step_cyc) begin
      step_cnt_ff <= 16'h0000;
      ramp_ff <= (ramp_ff < level_code) ? ramp_ff + 10'h001 : ramp_ff - 10'h001;
    end else begin
      step_cnt_ff <= step_cnt_ff + 16'h0001;
    end
  end

  // Compensation and current scaling; a wide constant divider, area for simplicity
  wire [4:0] comp_k = regs_ff[led_dim_pkg::ADDR_COMP[3:0]][led_dim_pkg::COMP_K_MSB:0];
  wire [7:0] stop_duty = regs_ff[led_dim_pkg::ADDR_STOP[3:0]];
  wire [7:0] full_scale_led_current = regs_ff[led_dim_pkg::ADDR_CURRENT[3:0]];
  logic [24:0] bend;
  logic [9:0] comp_code;
  logic [17:0] cur;
  always_comb begin
    bend = 25'(ramp_ff * (led_dim_pkg::FULL_CODE - ramp_ff) * comp_k) /
           25'(led_dim_pkg::FULL_CODE * led_dim_pkg::COMP_DIV);
    comp_code = ramp_ff - bend[9:0];
    if (stop_duty != 8'h00 && ramp_ff[9:2] >= stop_duty) begin
      comp_code = ramp_ff;
    end
    cur = 18'(full_scale_led_current * comp_code) / 18'(led_dim_pkg::FULL_CODE);
  end

  // Lowest sink to the error amplifier
  logic [7:0] fb_min;
  always_comb begin
    fb_min = sink_feedback_voltage_i[7:0];
    for (int i = 1; i < 6; i++) begin
      if (sink_feedback_voltage_i[i*8 +: 8] < fb_min) begin
        fb_min = sink_feedback_voltage_i[i*8 +: 8];
      end
    end
  end

  // Output period; duty and DC mode only change at the wrap
  logic [9:0] per_ff, duty_ff;
  logic dc_ff;
  wire per_end = (per_ff == led_dim_pkg::FULL_CODE - 10'h001);
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      per_ff <= 10'h000;
      duty_ff <= 10'h000;
      dc_ff <= 1'b0;
    end else if (per_end) begin
      per_ff <= 10'h000;
      duty_ff <= duty_code;
      dc_ff <= dc_mode;
    end else begin
      per_ff <= per_ff + 10'h001;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      dimming_output_duty_o <= 1'b0;
      full_scale_led_current_o <= 8'h00;
      error_amplifier_o <= 8'h00;
      headroom_target_mv_o <= led_dim_pkg::HEAD_MV0;
      register_dc_dimming_mode_o <= 1'b0;
    end else begin
      dimming_output_duty_o <= dc_ff | (per_ff < duty_ff);
      full_scale_led_current_o <= cur[7:0];
      error_amplifier_o <= fb_min;
      register_dc_dimming_mode_o <= dc_ff;
      case (adv[led_dim_pkg::ADV_HEAD_LSB+1:led_dim_pkg::ADV_HEAD_LSB])
        2'b00: headroom_target_mv_o <= led_dim_pkg::HEAD_MV0;
        2'b01: headroom_target_mv_o <= led_dim_pkg::HEAD_MV1;
        2'b10: headroom_target_mv_o <= led_dim_pkg::HEAD_MV2;
        default: headroom_target_mv_o <= led_dim_pkg::HEAD_MV3;
      endcase
    end
  end

  property p_dc_high;
    @(posedge sys_clk_i) disable iff (!rst_b_i) dc_ff |=> dimming_output_duty_o;
  endproperty
  a_dc_high: assert property (p_dc_high) else $error("DC mode output not high");

  property p_duty_hold;
    @(posedge sys_clk_i) disable iff (!rst_b_i) !per_end |=> $stable(duty_ff) && $stable(dc_ff);
  endproperty
  a_duty_hold: assert property (p_duty_hold) else $error("duty changed mid period");

  property p_no_comp;
    @(posedge sys_clk_i) disable iff (!rst_b_i) (comp_k == 5'h00) |-> comp_code == ramp_ff;
  endproperty
  a_no_comp: assert property (p_no_comp) else $error("compensation with zero ratio");

  property p_stop_comp;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
      (stop_duty != 8'h00 && ramp_ff[9:2] >= stop_duty) |-> comp_code == ramp_ff;
  endproperty
  a_stop_comp: assert property (p_stop_comp) else $error("compensation past stop duty");

  property p_fb_min;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
      ##1 error_amplifier_o <= $past(sink_feedback_voltage_i[15:8]) &&
          error_amplifier_o <= $past(sink_feedback_voltage_i[47:40]);
  endproperty
  a_fb_min: assert property (p_fb_min) else $error("feedback minimum wrong");

  property p_pair_hold;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
      (wr_stb_ff && ten_bit && wr_addr_ff == led_dim_pkg::ADDR_P1_LO) |=> $stable(pair1_ff);
  endproperty
  a_pair_hold: assert property (p_pair_hold) else $error("pair applied on first half");

  property p_plain_pwm;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
      (!mode[led_dim_pkg::MODE_26K_BIT] && !src_reg && adv[led_dim_pkg::ADV_SEL_MSB:0] == 2'b00)
        |-> level_code == pwm_duty_ff && duty_code == pwm_duty_ff;
  endproperty
  a_plain_pwm: assert property (p_plain_pwm) else $error("plain mode not following input");

  property p_soft_stretch;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
      (soft_ff && !dither_en && fade[led_dim_pkg::FADE_TIME_LSB+1:led_dim_pkg::FADE_TIME_LSB] == 2'b00)
        |-> step_cyc == (led_dim_pkg::FADE_C0 << ss_mult);
  endproperty
  a_soft_stretch: assert property (p_soft_stretch) else $error("soft start stretch wrong");

  property p_dither_off;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
      (!dither_en && !soft_ff && fade[led_dim_pkg::FADE_TIME_LSB+1:led_dim_pkg::FADE_TIME_LSB] == 2'b00)
        |-> step_cyc == led_dim_pkg::FADE_C0;
  endproperty
  a_dither_off: assert property (p_dither_off) else $error("fade time not used");
endmodule

// ---- led_dimming_control_tb.sv ----
`timescale 1ns/1ps
module led_dimming_control_tb;
  localparam logic [7:0] RST_ADDR [8] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h08, 8'h09, 8'h0a, 8'h0b};
  localparam logic [7:0] RST_VAL [8] = '{8'h40, 8'h76, 8'h92, 8'h00, 8'h00, 8'h1c, 8'h00, 8'h00};
  localparam logic [9:0] HEAD_EXP [4] = '{10'h1f4, 10'h23a, 10'h258, 10'h2bc};
  logic sys_clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic [47:0] sink_feedback_voltage_i = 48'h0;
  logic scl, sda_pull, duty, sda_o, sda_oe_o, dimming_output_duty_o, register_dc_dimming_mode_o, nack;
  logic [7:0] full_scale_led_current_o, error_amplifier_o, q;
  logic [9:0] headroom_target_mv_o;
  int bad_count = 0;
  int comparisons = 0;
  int t;
  // Open-drain SDA with a pull-up: low whenever either side pulls
  wire logic sda_wire = ~(sda_pull | (sda_oe_o & ~sda_o));
  always #50 sys_clk_i = ~sys_clk_i;
  i2c_host_model u_host (.sys_clk_i(sys_clk_i), .sda_i(sda_wire), .scl_o(scl), .sda_pull_o(sda_pull), .duty_o(duty));
  led_dimming_control u_dut (
    .sys_clk_i(sys_clk_i),
    .rst_b_i(rst_b_i),
    .scl_i(scl),
    .sda_i(sda_wire),
    .sda_o(sda_o),
    .sda_oe_o(sda_oe_o),
    .external_duty_input_i(duty),
    .sink_feedback_voltage_i(sink_feedback_voltage_i),
    .dimming_output_duty_o(dimming_output_duty_o),
    .full_scale_led_current_o(full_scale_led_current_o),
    .error_amplifier_o(error_amplifier_o),
    .headroom_target_mv_o(headroom_target_mv_o),
    .register_dc_dimming_mode_o(register_dc_dimming_mode_o)
  );
  function automatic logic [7:0] comp_cur(input int full_scale_led_current, input int code, input int k);
    int c;
    c = code - code * (1023 - code) * k / 1023 / 31;
    return 8'(full_scale_led_current * c / 1023);
  endfunction
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic check_val(input string what, input logic [9:0] exp, input logic [9:0] got);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic check_range(input string what, input int lo, input int hi, input int got);
    comparisons++;
    if (got < lo || got > hi) begin
      bad_count++;
      $display("wrong value %s expected %0d to %0d seen %0d", what, lo, hi, got);
    end
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    u_host.write_reg(7'h31, a, d, nack);
  endtask
  // Bounded wait for the current code, then a compare; the wait length is returned for timing checks
  task automatic wait_cur(input logic [7:0] exp, input int limit, output int n);
    n = 0;
    while (full_scale_led_current_o !== exp && n < limit) begin
      settle(1);
      n++;
    end
    check_val("led current", {2'h0, exp}, {2'h0, full_scale_led_current_o});
  endtask
  task automatic count_high(output int n);
    n = 0;
    // Let a full output period pass so the latched duty is the new one
    settle(1030);
    repeat (1023) begin
      settle(1);
      n += (dimming_output_duty_o === 1'b1);
    end
  endtask
  initial begin
    #(100 * 100000);
    bad_count++;
    $display("watchdog expired");
    print_verdict();
  end
  initial begin
    repeat (2) @(posedge sys_clk_i);
    rst_b_i <= 1'b1;
    settle(4);
    check_val("headroom after reset", 10'h1f4, headroom_target_mv_o);
    for (int i = 0; i < 8; i++) begin
      u_host.read_reg(RST_ADDR[i], q);
      check_val("reset value", {2'h0, RST_VAL[i]}, {2'h0, q});
    end
    u_host.write_reg(7'h12, 8'h0b, 8'h55, nack);
    check_val("foreign address nack", 10'h001, {9'h0, nack});
    u_host.read_reg(8'h0b, q);
    check_val("stop duty untouched", 10'h000, {2'h0, q});
    wr(8'h0b, 8'ha5);
    u_host.read_reg(8'h0b, q);
    check_val("stop duty readback", 10'h0a5, {2'h0, q});
    wr(8'h0b, 8'h00);
    wr(8'h0c, 8'h5a);
    u_host.read_reg(8'h0c, q);
    check_val("unmapped read", 10'h000, {2'h0, q});
    for (int c = 0; c < 4; c++) begin
      wr(8'h08, 8'(c << 2));
      settle(3);
      check_val("headroom", HEAD_EXP[c], headroom_target_mv_o);
    end
    @(posedge sys_clk_i);
    sink_feedback_voltage_i <= 48'h7f21_3390_2055;
    settle(3);
    check_val("lowest feedback", 10'h020, {2'h0, error_amplifier_o});
    @(posedge sys_clk_i);
    sink_feedback_voltage_i <= 48'h0521_3390_2055;
    settle(3);
    check_val("lowest feedback", 10'h005, {2'h0, error_amplifier_o});
    // Dither off so register levels land at once outside DC mode
    wr(8'h09, 8'h0c);
    u_host.duty_high = 1023;
    // Soft start still ramps this first target, 5 clocks a step
    wait_cur(8'h92, 8000, t);
    count_high(t);
    check_range("full output duty", 1021, 1023, t);
    u_host.duty_high = 512;
    settle(3000);
    count_high(t);
    check_range("half output duty", 509, 515, t);
    u_host.duty_high = 1023;
    wr(8'h04, 8'h80);
    wr(8'h08, 8'h01);
    wait_cur(8'h49, 5000, t);
    wr(8'h08, 8'h02);
    wait_cur(8'h00, 5000, t);
    wr(8'h08, 8'h00);
    wait_cur(8'h92, 5000, t);
    u_host.duty_high = 0;
    wr(8'h00, 8'hc2);
    wait_cur(8'h49, 5000, t);
    count_high(t);
    check_range("register output duty", 511, 517, t);
    wr(8'h03, 8'h1f);
    wait_cur(comp_cur(146, 514, 31), 5000, t);
    wr(8'h0b, 8'h81);
    settle(200);
    check_val("below stop duty", {2'h0, comp_cur(146, 514, 31)}, {2'h0, full_scale_led_current_o});
    wr(8'h0b, 8'h80);
    wait_cur(8'h49, 5000, t);
    wr(8'h0b, 8'h00);
    wait_cur(comp_cur(146, 514, 31), 5000, t);
    wr(8'h01, 8'hf6);
    wr(8'h04, 8'hff);
    settle(200);
    check_val("lower half only", {2'h0, comp_cur(146, 514, 31)}, {2'h0, full_scale_led_current_o});
    wr(8'h05, 8'h03);
    wait_cur(8'h92, 5000, t);
    wr(8'h03, 8'h00);
    wr(8'h00, 8'hc3);
    settle(2100);
    check_val("dc mode", 10'h001, {9'h0, register_dc_dimming_mode_o});
    count_high(t);
    check_range("dc output high", 1023, 1023, t);
    // Ramp 1023 down to 259, where the current first shows the target, at 5 clocks a step
    wr(8'h05, 8'h00);
    wait_cur(comp_cur(146, 255, 0), 6000, t);
    check_range("fade time", 3600, 3900, t);
    print_verdict();
  end
endmodule

// ---- sync2.sv ----
`timescale 1ns/1ps
module sync2 #(
  parameter int WIDTH = 1
) (
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_ff;

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      meta_ff <= '0;
      sync_o <= '0;
    end else begin
      meta_ff <= async_i;
      sync_o <= meta_ff;
    end
  end
endmodule
